// [adc_status_mode_regs.svh]
// register map, field positions, encodings and bit counts of the status and mode registers
`ifndef ADC_STATUS_MODE_REGS_SVH
`define ADC_STATUS_MODE_REGS_SVH

// register select codes carried in the command byte
`define RS_STATUS 2'b00
`define RS_MODE 2'b01
`define RS_RSVD 2'b10
`define RS_DATA 2'b11

// mode register reset value and field positions
`define MODE_RESET 8'h02
`define MODE_OPM_HI 7
`define MODE_OPM_LO 6
`define MODE_POL_BIT 2
`define MODE_STANDBY_BIT 7

// operating mode field encodings
`define OPM_CONT 2'b00
`define OPM_SINGLE 2'b01
`define OPM_STANDBY 2'b11

// status register fixed field (bits 5..3) and reset flag values
`define STAT_FIXED 3'h1
`define STAT_NOT_READY_RST 1'b1
`define STAT_ERR_RST 1'b0
`define CHAN_RESET 2'h0

// command byte field positions after the enable bit
`define CMD_RS_HI 5
`define CMD_RS_LO 4
`define CMD_RW 3
`define CMD_CH_HI 1
`define CMD_CH_LO 0

// serial bit counts
`define CMD_LAST 5'h06
`define BYTE_LAST 5'h07
`define WIDE_LAST 5'h17
`define NARROW_LAST 5'h0f
`define ONES_LAST 6'h1f

`endif

// [adc_status_mode_pkg.sv]
// types shared by the status and mode register logic
package adc_status_mode_pkg;

  // serial link phases
  typedef enum logic [1:0] {
    LINK_HUNT = 2'b00,
    LINK_CMD = 2'b01,
    LINK_WRITE = 2'b10,
    LINK_READ = 2'b11
  } link_phase_t;

  // link side state, clocked by the serial clock
  typedef struct packed {
    link_phase_t phase;
    logic [4:0] cnt;
    logic [5:0] cmd;
    logic [23:0] shreg;
    logic [7:0] mode_wdata;
    logic [1:0] chan;
    logic [1:0] rs;
    logic [5:0] ones;
    logic dout;
    logic snap_tog;
    logic cmd_tog;
    logic mode_tog;
    logic read_tog;
    logic reset_tog;
  } link_state_t;

  // converter side state, clocked by the system clock
  typedef struct packed {
    logic not_ready;
    logic err;
    logic [7:0] mode;
    logic [1:0] channel;
    logic [23:0] data;
    logic [7:0] sh_status;
    logic [7:0] sh_mode;
    logic [23:0] sh_data;
    logic mod_reset;
    logic mod_run;
  } core_state_t;

  // synchroniser stages
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_state_t;

  // toggle to pulse stages
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } toggle_state_t;

endpackage

// [bit_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  adc_status_mode_pkg::sync_state_t st_r; // stage pair
  adc_status_mode_pkg::sync_state_t st_nxt; // next stage pair

  ////////////////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  // stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;

endmodule

// [toggle_event.sv]
// toggle to one-cycle pulse crossing with clock enable
`timescale 1ns/1ps
module toggle_event (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tog,
  output logic pulse
);

  adc_status_mode_pkg::toggle_state_t st_r; // sync stages and edge memory
  adc_status_mode_pkg::toggle_state_t st_nxt; // next stages

  ////////////////////////////////////////////////////////////////////////////
  // two stage sync, third stage remembers the last seen level
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.s1 = tog;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
    end
  end

  // stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // pulse while the settled level differs from the remembered one
  assign pulse = ce & (st_r.s2 ^ st_r.s3);

endmodule

// [adc_status_mode_registers.sv]
// status and mode registers of the converter with their three-wire serial link
`timescale 1ns/1ps
`include "adc_status_mode_regs.svh"

module adc_status_mode_registers #(
  parameter logic WIDE_VARIANT = 1'b1 // resolution variant flag, value chosen freely
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic din,
  output logic dout_rdy,
  input wire logic conv_done,
  input wire logic [23:0] conv_result,
  input wire logic conv_clamped,
  input wire logic conv_pre_update,
  output logic modulator_reset,
  output logic modulator_run,
  output logic [1:0] operating_mode_field,
  output logic unipolar_coding,
  output logic [1:0] input_channel_field
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  adc_status_mode_pkg::link_state_t link_r; // serial clock domain state
  adc_status_mode_pkg::link_state_t link_nxt; // its next value
  adc_status_mode_pkg::core_state_t core_r; // system clock domain state
  adc_status_mode_pkg::core_state_t core_nxt; // its next value

  logic rdy_sync; // ready level (inverted flag) seen in the serial clock domain
  logic snap_ev; // host started a command byte
  logic cmd_ev; // command byte complete, channel bits valid
  logic mode_ev; // mode byte complete
  logic read_ev; // data register fully shifted out
  logic reset_ev; // long run of ones seen on din
  logic [7:0] status_now; // live status byte
  logic [6:0] cmd_full; // command bits including the one arriving now
  logic [4:0] read_last; // index of last bit for the selected read

  ////////////////////////////////////////////////////////////////////////////
  // crossings between the two domains

  // ready level into the serial domain for the idle pin; crossed inverted so the
  // cleared synchroniser after reset reads as not ready, never as a false ready
  bit_sync u_rdy_sync (
    .clk(sclk),
    .rst_n(rst_n),
    .d(~core_r.not_ready),
    .q(rdy_sync)
  );

  // command start: asks for a fresh register snapshot
  toggle_event u_snap_ev (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tog(link_r.snap_tog),
    .pulse(snap_ev)
  );

  // command end: channel bits are stable in link_r.chan
  toggle_event u_cmd_ev (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tog(link_r.cmd_tog),
    .pulse(cmd_ev)
  );

  // mode byte end: link_r.mode_wdata is stable until the next write
  toggle_event u_mode_ev (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tog(link_r.mode_tog),
    .pulse(mode_ev)
  );

  // data register read finished
  toggle_event u_read_ev (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tog(link_r.read_tog),
    .pulse(read_ev)
  );

  // interface reset by a run of ones
  toggle_event u_reset_ev (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .tog(link_r.reset_tog),
    .pulse(reset_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // serial link, clocked by the host clock

  // command bits as they stand after the current edge
  assign cmd_full = {link_r.cmd, din};

  // read length depends on the register and the variant
  assign read_last = (link_r.rs != `RS_DATA) ? `BYTE_LAST :
                     (WIDE_VARIANT ? `WIDE_LAST : `NARROW_LAST);

  // link sequencer: hunt for enable bit, take command, move a byte or word
  always_comb begin
    link_nxt = link_r;
    // count ones on din for the interface reset
    if (din) begin
      link_nxt.ones = link_r.ones + 6'h01;
    end else begin
      link_nxt.ones = '0;
    end
    case (link_r.phase)
      adc_status_mode_pkg::LINK_HUNT: begin
        // pin shows the not-ready flag while idle
        link_nxt.dout = ~rdy_sync;
        if (!din) begin
          // enable bit low: command follows
          link_nxt.phase = adc_status_mode_pkg::LINK_CMD;
          link_nxt.cnt = '0;
          link_nxt.snap_tog = ~link_r.snap_tog;
        end
      end
      adc_status_mode_pkg::LINK_CMD: begin
        link_nxt.cmd = cmd_full[5:0];
        link_nxt.cnt = link_r.cnt + 5'h01;
        if (link_r.cnt == `CMD_LAST) begin
          // decode select, direction and channel
          link_nxt.rs = cmd_full[`CMD_RS_HI:`CMD_RS_LO];
          link_nxt.chan = cmd_full[`CMD_CH_HI:`CMD_CH_LO];
          link_nxt.cmd_tog = ~link_r.cmd_tog;
          link_nxt.cnt = '0;
          if (cmd_full[`CMD_RW]) begin
            // read: load the snapshot, first bit out at once
            link_nxt.phase = adc_status_mode_pkg::LINK_READ;
            case (cmd_full[`CMD_RS_HI:`CMD_RS_LO])
              `RS_STATUS: link_nxt.shreg = {core_r.sh_status, 16'h0000};
              `RS_MODE: link_nxt.shreg = {core_r.sh_mode, 16'h0000};
              `RS_DATA: link_nxt.shreg = core_r.sh_data;
              default: link_nxt.shreg = '0;
            endcase
            link_nxt.dout = link_nxt.shreg[23];
          end else if (cmd_full[`CMD_RS_HI:`CMD_RS_LO] == `RS_MODE) begin
            link_nxt.phase = adc_status_mode_pkg::LINK_WRITE;
          end else begin
            // status, reserved and data writes go nowhere
            link_nxt.phase = adc_status_mode_pkg::LINK_HUNT;
          end
        end
      end
      adc_status_mode_pkg::LINK_WRITE: begin
        // mode byte arrives msb first
        link_nxt.mode_wdata = {link_r.mode_wdata[6:0], din};
        link_nxt.cnt = link_r.cnt + 5'h01;
        if (link_r.cnt == `BYTE_LAST) begin
          link_nxt.mode_tog = ~link_r.mode_tog;
          link_nxt.phase = adc_status_mode_pkg::LINK_HUNT;
        end
      end
      adc_status_mode_pkg::LINK_READ: begin
        // advance to the next bit after the host sampled this one
        link_nxt.shreg = {link_r.shreg[22:0], 1'b0};
        link_nxt.dout = link_r.shreg[22];
        link_nxt.cnt = link_r.cnt + 5'h01;
        if (link_r.cnt == read_last) begin
          link_nxt.phase = adc_status_mode_pkg::LINK_HUNT;
          link_nxt.dout = ~rdy_sync;
          if (link_r.rs == `RS_DATA) begin
            link_nxt.read_tog = ~link_r.read_tog;
          end
        end
      end
      default: begin
        link_nxt.phase = adc_status_mode_pkg::LINK_HUNT;
      end
    endcase
    // thirty-two ones in a row return the interface to hunting
    if (din && (link_r.ones == `ONES_LAST)) begin
      link_nxt.phase = adc_status_mode_pkg::LINK_HUNT;
      link_nxt.ones = '0;
      link_nxt.reset_tog = ~link_r.reset_tog;
    end
  end

  // link registers
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      link_r <= '0;
      link_r.dout <= `STAT_NOT_READY_RST;
    end else begin
      link_r <= link_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // converter side registers

  // live status byte; status is never written by the link
  assign status_now = {core_r.not_ready, core_r.err, `STAT_FIXED,
                       WIDE_VARIANT, core_r.channel};

  // flag updates; later assignments take priority so not-ready sets win, while err is cleared by channel change and mode write
  always_comb begin
    core_nxt = core_r;
    core_nxt.mod_reset = 1'b0;
    if (ce) begin
      // new result from the filter
      if (conv_done && core_r.mod_run) begin
        core_nxt.data = conv_result;
        core_nxt.not_ready = 1'b0;
        core_nxt.err = conv_clamped;
        if (core_r.mode[`MODE_OPM_HI:`MODE_OPM_LO] == `OPM_SINGLE) begin
          // single conversion done: modulator powers down, result kept
          core_nxt.mod_run = 1'b0;
        end
      end
      // result about to be overwritten, or just read
      if (conv_pre_update || read_ev) begin
        core_nxt.not_ready = 1'b1;
      end
      // channel change restarts the conversion
      if (cmd_ev && (link_r.chan != core_r.channel)) begin
        core_nxt.channel = link_r.chan;
        core_nxt.mod_reset = 1'b1;
        core_nxt.err = 1'b0;
        core_nxt.mod_run = ~core_r.mode[`MODE_STANDBY_BIT];
      end
      // mode write restarts modulator and filter
      if (mode_ev) begin
        core_nxt.mode = link_r.mode_wdata;
        core_nxt.mod_reset = 1'b1;
        core_nxt.not_ready = 1'b1;
        core_nxt.err = 1'b0;
        core_nxt.mod_run = ~link_r.mode_wdata[`MODE_STANDBY_BIT];
      end
      // run of ones restores mode and flag defaults; channel kept
      if (reset_ev) begin
        core_nxt.mode = `MODE_RESET;
        core_nxt.not_ready = `STAT_NOT_READY_RST;
        core_nxt.err = `STAT_ERR_RST;
        core_nxt.mod_reset = 1'b1;
        core_nxt.mod_run = 1'b1;
      end
      // snapshot held still while the link shifts it out
      if (snap_ev) begin
        core_nxt.sh_status = status_now;
        core_nxt.sh_mode = core_r.mode;
        core_nxt.sh_data = core_r.data;
      end
    end
  end

  // converter side registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_r <= '0;
      core_r.not_ready <= `STAT_NOT_READY_RST;
      core_r.err <= `STAT_ERR_RST;
      core_r.mode <= `MODE_RESET;
      core_r.channel <= `CHAN_RESET;
      core_r.mod_run <= 1'b1;
    end else begin
      core_r <= core_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a register bit

  assign dout_rdy = link_r.dout;
  assign modulator_reset = core_r.mod_reset;
  assign modulator_run = core_r.mod_run;
  assign operating_mode_field = core_r.mode[`MODE_OPM_HI:`MODE_OPM_LO];
  assign unipolar_coding = core_r.mode[`MODE_POL_BIT];
  assign input_channel_field = core_r.channel;

endmodule

// [adc_status_mode_registers_assertions.sv]
// concurrent checks on the converter-side ports of the status and mode registers
`timescale 1ns/1ps
module adc_status_mode_registers_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic conv_done,
  input wire logic modulator_reset,
  input wire logic modulator_run,
  input wire logic [1:0] operating_mode_field,
  input wire logic unipolar_coding,
  input wire logic [1:0] input_channel_field
);
  // every check runs on the system clock and rests while reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  // reset values and the restart pulse
  chk_reset_state_vals: assert property ($rose(rst_n) |-> modulator_run && !unipolar_coding
    && operating_mode_field == 2'b00 && input_channel_field == 2'b00 && !modulator_reset)
    else $error("outputs wrong right after reset");
  chk_restart_one_cycle: assert property (modulator_reset |=> !modulator_reset)
    else $error("modulator restart longer than one cycle");
  // a new mode, polarity or channel is always accompanied by a restart
  chk_mode_restart: assert property ($changed(operating_mode_field) |->
    (modulator_reset || $past(modulator_reset)) or ##[1:3] modulator_reset)
    else $error("mode field changed without restart");
  chk_coding_restart: assert property ($changed(unipolar_coding) |->
    (modulator_reset || $past(modulator_reset)) or ##[1:3] modulator_reset)
    else $error("polarity changed without restart");
  chk_channel_restart: assert property ($changed(input_channel_field) |->
    (modulator_reset || $past(modulator_reset)) or ##[1:3] modulator_reset)
    else $error("channel changed without restart");
  ////////////////////////////////////////////////////////////////////////////
  // operating mode against modulator power
  chk_standby_off: assert property (operating_mode_field[1] [*3] |-> !modulator_run)
    else $error("modulator running in standby");
  chk_cont_runs: assert property ((operating_mode_field == 2'b00) [*3] |-> modulator_run)
    else $error("modulator stopped in continuous mode");
  chk_single_stop: assert property ((operating_mode_field == 2'b01 && conv_done && ce
    && modulator_run) |-> ##[1:3] !modulator_run)
    else $error("single conversion did not power down");
endmodule
bind adc_status_mode_registers adc_status_mode_registers_assertions chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .ce(ce),
  .conv_done(conv_done),
  .modulator_reset(modulator_reset),
  .modulator_run(modulator_run),
  .operating_mode_field(operating_mode_field),
  .unipolar_coding(unipolar_coding),
  .input_channel_field(input_channel_field)
);

// [host_link.sv]
// host model of the three-wire link: command frames, write bytes, read words
`timescale 1ns/1ps
module host_link (
  output logic sclk,
  output logic din,
  input wire logic dout_rdy,
  output logic rd_valid,
  output logic [23:0] rd_data
);
  // link clock stands high and din idles high between frames
  initial begin
    sclk = 1'b1;
    din = 1'b1;
    rd_valid = 1'b0;
    rd_data = 24'h000000;
  end
  // one 12 ns link period, read bit taken at the rising edge
  task automatic tick(input logic b, input logic smp);
    sclk = 1'b0;
    din = b;
    #6;
    if (smp) rd_data = {rd_data[22:0], dout_rdy};
    sclk = 1'b1;
    #6;
  endtask
  // enable bit and seven command bits, then n data bits msb first
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n);
    #1.3;
    rd_data = 24'h000000;
    for (int i = 7; i >= 0; i--) tick(cmd[i], 1'b0);
    for (int i = n - 1; i >= 0; i--) tick(cmd[3] ? 1'b0 : wd[i], cmd[3]);
    din = 1'b1;
    if (cmd[3]) begin
      rd_valid = 1'b1;
      #1;
      rd_valid = 1'b0;
    end
  endtask
  // 32 ones in a row restore the power-on mode and flags; the channel is kept
  task automatic ones();
    for (int i = 0; i < 32; i++) tick(1'b1, 1'b0);
  endtask
endmodule

// [adc_status_mode_registers_tb.sv]
// self-checking bench for the status and mode registers
`timescale 1ns/1ps
module adc_status_mode_registers_tb;
  logic clk, rst_n, ce, conv_done, conv_clamped, conv_pre_update; // converter side
  logic [23:0] conv_result;
  logic sclk, din, dout_rdy, rd_valid, modulator_reset, modulator_run, unipolar_coding;
  logic [1:0] operating_mode_field, input_channel_field;
  logic [23:0] rd_data;
  logic [23:0] expq[$]; // expected read words, oldest first
  int failures, num_checks;
  logic [15:0] lfsr; // stimulus source
  logic [1:0] ch, md; // channel in use, mode field
  logic nr, er; // expected not-ready and error flags
  logic [7:0] m;
  ////////////////////////////////////////////////////////////////////////////
  adc_status_mode_registers #(.WIDE_VARIANT(1'b1)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
    .sclk(sclk), .din(din), .dout_rdy(dout_rdy), .conv_done(conv_done),
    .conv_result(conv_result), .conv_clamped(conv_clamped),
    .conv_pre_update(conv_pre_update), .modulator_reset(modulator_reset),
    .modulator_run(modulator_run), .operating_mode_field(operating_mode_field),
    .unipolar_coding(unipolar_coding), .input_channel_field(input_channel_field));
  host_link host (.sclk(sclk), .din(din), .dout_rdy(dout_rdy), .rd_valid(rd_valid),
    .rd_data(rd_data));
  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one converter strobe cycle, then time to settle
  task automatic strobe(input logic d, input logic cl, input logic pu);
    @(posedge clk);
    conv_done <= d;
    conv_clamped <= cl;
    conv_pre_update <= pu;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_clamped <= 1'b0;
    conv_pre_update <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // read n bits from select rs, noting what should come back
  task automatic rd(input logic [1:0] rs, input logic [23:0] exp, input int n);
    expq.push_back(exp);
    host.xfer({2'b00, rs, 2'b10, ch}, 8'h00, n);
    repeat (8) @(posedge clk);
  endtask
  task automatic stat();
    rd(2'b00, {16'h0000, nr, er, 3'b001, 1'b1, ch}, 8);
  endtask
  // mode write followed by a bounded wait for the restart pulse
  task automatic wr_mode(input logic [7:0] v);
    int i;
    host.xfer({2'b00, 2'b01, 2'b00, ch}, v, 8);
    for (i = 0; i < 20 && modulator_reset !== 1'b1; i++) @(posedge clk);
    check({23'h0, modulator_reset}, 24'h1);
    if (i == 20) results();
    repeat (8) @(posedge clk);
  endtask
  // watcher: each finished read is compared with the oldest note
  initial forever begin
    @(posedge rd_valid);
    if (expq.size() == 0) check(rd_data, 24'hffffff);
    else check(rd_data, expq.pop_front());
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, conv_done, conv_clamped, conv_pre_update} = 4'h0;
    ce = 1'b1;
    conv_result = 24'h000000;
    lfsr = 16'h002c;
    {failures, num_checks} = 0;
    {ch, nr, er} = 4'h2;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    stat();
    rd(2'b01, 24'h000002, 8);
    host.xfer({2'b00, 2'b00, 2'b00, ch}, 8'h00, 0);
    repeat (8) @(posedge clk);
    stat();
    lfsr = lfsr_next(lfsr);
    conv_result <= {lfsr, lfsr[7:0] ^ 8'h5a};
    strobe(1'b1, 1'b0, 1'b0);
    nr = 1'b0;
    stat();
    check({23'h0, dout_rdy}, 24'h0);
    rd(2'b11, {lfsr, lfsr[7:0] ^ 8'h5a}, 24);
    nr = 1'b1;
    stat();
    check({23'h0, dout_rdy}, 24'h1);
    strobe(1'b1, 1'b0, 1'b0);
    strobe(1'b0, 1'b0, 1'b1);
    stat();
    strobe(1'b1, 1'b1, 1'b0);
    {nr, er} = 2'b01;
    // clock enable low: a pre-update strobe must leave the flags alone
    ce <= 1'b0;
    strobe(1'b0, 1'b0, 1'b1);
    ce <= 1'b1;
    stat();
    wr_mode(8'h02);
    {nr, er} = 2'b10;
    stat();
    // every operating mode, polarity from the stimulus source
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      md = (k == 2) ? 2'b11 : k[1:0];
      m = {md, 3'b000, lfsr[0], 2'b10};
      wr_mode(m);
      check({22'h0, operating_mode_field}, {22'h0, md});
      check({23'h0, unipolar_coding}, {23'h0, lfsr[0]});
      rd(2'b01, {16'h0000, m}, 8);
      if (k == 1) begin
        strobe(1'b1, 1'b0, 1'b0);
        check({23'h0, modulator_run}, 24'h0);
      end
    end
    check({23'h0, modulator_run}, 24'h0);
    stat();
    // new channel: the read shows the old one, later reads the new
    m[1:0] = ch;
    ch = ch + 2'b01 + {1'b0, lfsr[1]};
    rd(2'b00, {16'h0000, nr, er, 3'b001, 1'b1, m[1:0]}, 8);
    check({22'h0, input_channel_field}, {22'h0, ch});
    stat();
    rd(2'b10, 24'h000000, 8);
    host.ones();
    repeat (12) @(posedge clk);
    check({22'h0, operating_mode_field}, 24'h0);
    rd(2'b01, 24'h000002, 8);
    // second hardware reset in mid-run restores every default
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    check({22'h0, input_channel_field}, 24'h0);
    check({23'h0, modulator_run}, 24'h1);
    rst_n <= 1'b1;
    {ch, nr, er} = 4'h2;
    repeat (6) @(posedge clk);
    stat();
    results();
  end
endmodule
